// ---- design/servo_phase_pkg.sv ----
package servo_phase_pkg;

	localparam int RING_W = 8;
	localparam int NUM_PHASES = 16;
	localparam int PHASE_IDX_W = 4;

	// Crystal and reference rates, in kHz and in hundredths of a kHz.
	localparam int CRYSTAL_KHZ = 6600;
	localparam int REF_CENTI_KHZ = 41250;
	localparam int CLK_PERIOD_NS = 50;
	localparam int SYS_KHZ = 1000000 / CLK_PERIOD_NS;

	localparam int ACC_W = 16;
	localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(CRYSTAL_KHZ);
	localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(SYS_KHZ);
	localparam logic [ACC_W-1:0] ACC_RESET = 16'h0000;
	localparam logic [RING_W-1:0] RING_RESET = 8'h00;

	// Phase numbers in sixteenths of one reference cycle.
	localparam logic [PHASE_IDX_W-1:0] PH_EXC_B = 4'h0;
	localparam logic [PHASE_IDX_W-1:0] PH_EXC_A = 4'h4;
	localparam logic [PHASE_IDX_W-1:0] PH_REF_C = 4'h2;
	localparam logic [PHASE_IDX_W-1:0] PH_REF_D = 4'h6;
	localparam logic [PHASE_IDX_W-1:0] PH_REF_180 = 4'h8;
	localparam logic [PHASE_IDX_W-1:0] PH_REF_180_INV = 4'h0;
	localparam logic [1:0] POS_IDX_LOW = 2'h0;

	localparam int DUTY_CNT_W = 8;
	localparam logic [DUTY_CNT_W-1:0] DUTY_CNT_RESET = 8'h00;
	localparam logic [DUTY_CNT_W-1:0] DUTY_CNT_ONE = 8'h01;

	localparam int NUM_CMP = 3;
	localparam int CMP_ODD = 0;
	localparam int CMP_EVEN = 1;
	localparam int CMP_POS = 2;

	localparam int NUM_WIN = 3;
	localparam int WIN_FB = 0;
	localparam int WIN_C = 1;
	localparam int WIN_D = 2;

	typedef struct packed {
		logic min_speed_request;
		logic forward_select_n;
		logic detent_n;
	} seek_req_t;

	typedef struct packed {
		logic fwd_drive_on;
		logic rev_drive_on;
		logic speed_inc_on;
		logic odd_fb_connect;
		logic odd_fb_ground;
		logic even_fb_connect;
		logic even_fb_ground;
		logic position_on;
	} switch_ctl_t;

	typedef struct packed {
		logic odd_cmp;
		logic even_cmp;
		logic pos_cmp;
		logic quad_c;
		logic quad_d;
		logic code_e;
		logic code_f;
	} servo_timing_t;

	typedef struct packed {
		logic excitation_a;
		logic excitation_b;
	} excitation_t;

endpackage

// ---- design/phase_ring.sv ----
`timescale 1ns/10ps
module phase_ring (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	output logic [servo_phase_pkg::RING_W-1:0] ring_o,
	output logic step_o
);
	import servo_phase_pkg::*;

	logic [ACC_W-1:0] acc_r;
	logic [ACC_W-1:0] acc_nxt;
	logic [ACC_W-1:0] acc_sum;

	// The crystal rate is rebuilt from the system clock by a rate accumulator.
	always_comb begin
		acc_sum = acc_r + ACC_STEP;
		step_o = (acc_sum >= ACC_WRAP);
		acc_nxt = step_o ? (acc_sum - ACC_WRAP) : acc_sum;
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			acc_r <= ACC_RESET;
		end else begin
			acc_r <= acc_nxt;
		end
	end

	// Twisted ring: eight stages, sixteen states per reference cycle.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ring_o <= RING_RESET;
		end else if (step_o) begin
			ring_o <= {ring_o[RING_W-2:0], ~ring_o[RING_W-1]};
		end
	end

endmodule

// ---- design/phase_compare.sv ----
`timescale 1ns/10ps
module phase_compare (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic set_i,
	input wire logic clr_i,
	output logic q_o
);

	// Set takes priority when both edges land in one cycle.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q_o <= 1'b0;
		end else if (set_i) begin
			q_o <= 1'b1;
		end else if (clr_i) begin
			q_o <= 1'b0;
		end
	end

endmodule

// ---- design/head_servo_phase_logic.sv ----
`timescale 1ns/10ps
// Behaviour
// - Eight-stage shift register clocked continuously
// - Sixteen equal phases of reference square wave
// - Excitation A lags excitation B quarter cycle
// - Transducer phase cycles once per four tracks
// - Minimum-speed request switches extra speed increment
// - Forward select steers forward or reverse switch
// - Detent forces both drive switches off
// - Odd compare: set transducer fall, clear reference fall
// - Even compare uses inverted half-cycle reference
// - Compare duty ramps per four tracks forward
// - Feedback window from transducer XOR reference
// - Odd and even feedback switched complementarily
// - Quadrants C, D use own reference phases
// - Code flip-flops capture C, D; held in detent
// - Out of detent code follows C and D
// - Two-bit code selects one of four references
// - Detent enables position switch
module head_servo_phase_logic (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire servo_phase_pkg::seek_req_t seek_i,
	input wire logic transducer_phase_square_i,
	output servo_phase_pkg::excitation_t excitation_o,
	output servo_phase_pkg::switch_ctl_t switch_o,
	output servo_phase_pkg::servo_timing_t timing_o,
	output logic [servo_phase_pkg::NUM_PHASES-1:0] phases_o
);
	import servo_phase_pkg::*;

	// Expands the ring into its true outputs followed by its inverted outputs.
	function automatic logic [NUM_PHASES-1:0] expand_phases(input logic [RING_W-1:0] ring);
		expand_phases = {~ring, ring};
	endfunction

	// Picks one phase out of a sixteen-phase vector.
	function automatic logic phase_pick(input logic [NUM_PHASES-1:0] vec, input logic [PHASE_IDX_W-1:0] idx);
		phase_pick = vec[idx];
	endfunction

	logic [RING_W-1:0] ring;
	logic ring_step;
	logic [NUM_PHASES-1:0] phases;
	logic [NUM_PHASES-1:0] phases_prev_r;
	logic [NUM_PHASES-1:0] phase_fall;

	logic xdcr_meta_r;
	logic xdcr_sync_r;
	logic xdcr_prev_r;
	logic xdcr_fall;

	logic [PHASE_IDX_W-1:0] pos_idx;
	logic [NUM_CMP-1:0] cmp_clr;
	logic [NUM_CMP-1:0] cmp_q;

	logic [NUM_WIN-1:0] win_ref;
	logic [NUM_WIN-1:0] win_ref_fall;
	logic [NUM_WIN-1:0] win_r;

	logic code_c_r;
	logic code_d_r;
	logic code_e;
	logic code_f;

	phase_ring u_ring (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.ring_o(ring),
		.step_o(ring_step)
	);

	assign phases = expand_phases(ring);

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			phases_prev_r <= {NUM_PHASES{1'b0}};
		end else begin
			phases_prev_r <= phases;
		end
	end

	assign phase_fall = phases_prev_r & ~phases;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			excitation_o <= '0;
			phases_o <= {NUM_PHASES{1'b0}};
		end else begin
			excitation_o.excitation_a <= phase_pick(phases, PH_EXC_A);
			excitation_o.excitation_b <= phase_pick(phases, PH_EXC_B);
			phases_o <= phases;
		end
	end

	// The transducer return is asynchronous to the system clock.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			xdcr_meta_r <= 1'b0;
			xdcr_sync_r <= 1'b0;
			xdcr_prev_r <= 1'b0;
		end else begin
			xdcr_meta_r <= transducer_phase_square_i;
			xdcr_sync_r <= xdcr_meta_r;
			xdcr_prev_r <= xdcr_sync_r;
		end
	end

	assign xdcr_fall = xdcr_prev_r & ~xdcr_sync_r;

	// One transducer phase cycle spans four tracks, so the two-bit code
	// picks one of four references spaced a quarter cycle apart.
	assign pos_idx = {code_e, code_f, POS_IDX_LOW};

	always_comb begin
		cmp_clr = '0;
		cmp_clr[CMP_ODD] = phase_fall[PH_REF_180];
		cmp_clr[CMP_EVEN] = phase_fall[PH_REF_180_INV];
		cmp_clr[CMP_POS] = phase_pick(phase_fall, pos_idx);
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
			phase_compare u_cmp (
				.clk_sys_i(clk_sys_i),
				.rstn_i(rstn_i),
				.set_i(xdcr_fall),
				.clr_i(cmp_clr[gi]),
				.q_o(cmp_q[gi])
			);
		end
	endgenerate

	always_comb begin
		win_ref = '0;
		win_ref[WIN_FB] = phase_pick(phases, PH_REF_180);
		win_ref[WIN_C] = phase_pick(phases, PH_REF_C);
		win_ref[WIN_D] = phase_pick(phases, PH_REF_D);
		win_ref_fall = '0;
		win_ref_fall[WIN_FB] = phase_fall[PH_REF_180];
		win_ref_fall[WIN_C] = phase_fall[PH_REF_C];
		win_ref_fall[WIN_D] = phase_fall[PH_REF_D];
	end

	// Each window measures the XOR duty over one reference cycle and flips
	// at the half level, standing in for the integrator and comparator.
	generate
		for (gi = 0; gi < NUM_WIN; gi++) begin : g_win
			logic [DUTY_CNT_W-1:0] hi_cnt_r;
			logic [DUTY_CNT_W-1:0] tot_cnt_r;
			logic xor_now;
			assign xor_now = xdcr_sync_r ^ win_ref[gi];
			always_ff @(posedge clk_sys_i or negedge rstn_i) begin
				if (!rstn_i) begin
					hi_cnt_r <= DUTY_CNT_RESET;
					tot_cnt_r <= DUTY_CNT_RESET;
					win_r[gi] <= 1'b0;
				end else if (win_ref_fall[gi]) begin
					win_r[gi] <= ({hi_cnt_r, 1'b0} > {1'b0, tot_cnt_r});
					hi_cnt_r <= xor_now ? DUTY_CNT_ONE : DUTY_CNT_RESET;
					tot_cnt_r <= DUTY_CNT_ONE;
				end else begin
					if (xor_now && (hi_cnt_r != {DUTY_CNT_W{1'b1}})) begin
						hi_cnt_r <= hi_cnt_r + DUTY_CNT_ONE;
					end
					if (tot_cnt_r != {DUTY_CNT_W{1'b1}}) begin
						tot_cnt_r <= tot_cnt_r + DUTY_CNT_ONE;
					end
				end
			end
		end
	endgenerate

	// Code flip-flops hold their state while detent is asserted.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			code_c_r <= 1'b0;
			code_d_r <= 1'b0;
		end else if (seek_i.detent_n) begin
			code_c_r <= win_r[WIN_C];
			code_d_r <= win_r[WIN_D];
		end
	end

	// The XOR turns the quadrant pair into a binary count.
	assign code_e = code_c_r;
	assign code_f = code_c_r ^ code_d_r;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			timing_o <= '0;
		end else begin
			timing_o.odd_cmp <= cmp_q[CMP_ODD];
			timing_o.even_cmp <= cmp_q[CMP_EVEN];
			timing_o.pos_cmp <= cmp_q[CMP_POS];
			timing_o.quad_c <= win_r[WIN_C];
			timing_o.quad_d <= win_r[WIN_D];
			timing_o.code_e <= code_e;
			timing_o.code_f <= code_f;
		end
	end

	// Direction follows the seek logic's select, which reflects the carry.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			switch_o <= '0;
		end else begin
			switch_o.fwd_drive_on <= seek_i.detent_n & ~seek_i.forward_select_n;
			switch_o.rev_drive_on <= seek_i.detent_n & seek_i.forward_select_n;
			switch_o.speed_inc_on <= ~(~seek_i.min_speed_request);
			switch_o.even_fb_connect <= win_r[WIN_FB];
			switch_o.odd_fb_ground <= win_r[WIN_FB];
			switch_o.odd_fb_connect <= ~win_r[WIN_FB];
			switch_o.even_fb_ground <= ~win_r[WIN_FB];
			switch_o.position_on <= ~seek_i.detent_n;
		end
	end

endmodule

// ---- sim/seek_partner.sv ----
`timescale 1ns/10ps
module seek_partner (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic carry_i,
	input wire logic at_target_i,
	input wire logic min_speed_i,
	input wire logic exc_b_i,
	input wire logic [5:0] lag_i,
	output servo_phase_pkg::seek_req_t seek_o,
	output logic transducer_o
);
	import servo_phase_pkg::*;
	logic [63:0] hist_r;
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			seek_o <= '{1'h0, 1'h0, 1'h1};
		end else begin
			seek_o.min_speed_request <= min_speed_i;
			seek_o.forward_select_n <= carry_i;
			seek_o.detent_n <= !at_target_i;
		end
	end
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hist_r <= 64'h0;
		end else begin
			hist_r <= {hist_r[62:0], exc_b_i};
		end
	end
	// The head position shows as a delay of the returned square wave.
	assign transducer_o = hist_r[lag_i];
endmodule

// ---- sim/servo_phase_assertions.sv ----
`timescale 1ns/10ps
module servo_phase_assertions (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire servo_phase_pkg::seek_req_t seek_i,
	input wire logic transducer_phase_square_i,
	input wire servo_phase_pkg::excitation_t excitation_o,
	input wire servo_phase_pkg::switch_ctl_t switch_o,
	input wire servo_phase_pkg::servo_timing_t timing_o,
	input wire logic [servo_phase_pkg::NUM_PHASES-1:0] phases_o
);
	import servo_phase_pkg::*;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	sequence xd_fall_s;
		$fell(transducer_phase_square_i);
	endsequence
	sequence detent_held_s;
		!seek_i.detent_n [*3];
	endsequence
	phase_pair_a: assert property ($past(rstn_i) |-> phases_o[15:8] == ~phases_o[7:0])
		else $error("phase pair broken");
	ring_shift_a: assert property ($past(rstn_i) && $changed(phases_o[7:0])
		|-> phases_o[7:0] == {$past(phases_o[6:0]), !$past(phases_o[7])})
		else $error("ring step wrong");
	ring_runs_a: assert property ($past(rstn_i) |-> ##[1:5] $changed(phases_o[7:0]))
		else $error("ring stalled");
	drive_dir_a: assert property ($past(rstn_i, 2) |->
		switch_o.fwd_drive_on == $past(seek_i.detent_n && !seek_i.forward_select_n) &&
		switch_o.rev_drive_on == $past(seek_i.detent_n && seek_i.forward_select_n))
		else $error("drive switch wrong");
	detent_off_a: assert property (detent_held_s |->
		!switch_o.fwd_drive_on && !switch_o.rev_drive_on && switch_o.position_on)
		else $error("detent switches wrong");
	speed_inc_a: assert property ($past(rstn_i, 2) |->
		switch_o.speed_inc_on == $past(seek_i.min_speed_request))
		else $error("speed increment wrong");
	fb_comp_a: assert property ($past(rstn_i, 3) |-> switch_o.even_fb_connect != switch_o.odd_fb_connect &&
		switch_o.even_fb_connect == switch_o.odd_fb_ground &&
		switch_o.odd_fb_connect == switch_o.even_fb_ground)
		else $error("feedback not complementary");
	odd_set_a: assert property (xd_fall_s |-> ##[3:5] timing_o.odd_cmp)
		else $error("odd compare not set");
	even_set_a: assert property (xd_fall_s |-> ##[3:5] timing_o.even_cmp)
		else $error("even compare not set");
	code_hold_a: assert property (detent_held_s |-> $stable({timing_o.code_e, timing_o.code_f}))
		else $error("code moved in detent");
	pos_set_a: assert property (xd_fall_s |-> ##[3:5] timing_o.pos_cmp)
		else $error("position compare not set");
endmodule
bind head_servo_phase_logic servo_phase_assertions chk (
	.clk_sys_i(clk_sys_i),
	.rstn_i(rstn_i),
	.seek_i(seek_i),
	.transducer_phase_square_i(transducer_phase_square_i),
	.excitation_o(excitation_o),
	.switch_o(switch_o),
	.timing_o(timing_o),
	.phases_o(phases_o)
);

// ---- sim/tb_head_servo_phase_logic.sv ----
`timescale 1ns/10ps
module tb_head_servo_phase_logic;
	import servo_phase_pkg::*;
	logic clk_sys_i = 1'h0;
	logic rstn_i = 1'h0;
	logic carry = 1'h0;
	logic at_tgt = 1'h0;
	logic msr = 1'h0;
	logic [5:0] lag = 6'h4;
	logic xd;
	seek_req_t seek;
	excitation_t exc;
	switch_ctl_t sw;
	servo_timing_t tm;
	logic [15:0] ph;
	int num_errors = 0;
	int checks_done = 0;
	// Inputs {request, carry, on target} beside {fwd, rev, speed, position}.
	logic [6:0] rows [8] = '{7'h08, 7'h11, 7'h24, 7'h31, 7'h4a, 7'h53, 7'h66, 7'h73};
	initial begin
		forever #25 clk_sys_i = !clk_sys_i;
	end
	head_servo_phase_logic dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .seek_i(seek),
		.transducer_phase_square_i(xd), .excitation_o(exc), .switch_o(sw), .timing_o(tm), .phases_o(ph));
	seek_partner seeker (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .carry_i(carry), .at_target_i(at_tgt),
		.min_speed_i(msr), .exc_b_i(exc.excitation_b), .lag_i(lag), .seek_o(seek), .transducer_o(xd));
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("errors=%0d checks=%0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Counts compare high cycles over eight reference periods.
	task automatic duty(input logic [5:0] d, output int od, output int ev);
		@(posedge clk_sys_i);
		lag <= d;
		repeat (300) @(negedge clk_sys_i);
		od = 0;
		ev = 0;
		repeat (388) begin
			@(negedge clk_sys_i);
			od += tm.odd_cmp;
			ev += tm.even_cmp;
		end
	endtask
	initial begin
		int o1, e1, o2, e2, o3, e3, n;
		realtime t0;
		logic [7:0] rv;
		repeat (5) @(negedge clk_sys_i);
		check({ph, exc, sw, tm}, 64'h0);
		@(posedge clk_sys_i);
		rstn_i <= 1'h1;
		// The releasing edge still sees reset; the next edge loads the cleared ring.
		@(posedge clk_sys_i);
		@(negedge clk_sys_i);
		check(ph, 16'hff00);
		rv = 8'h0;
		repeat (16) begin
			n = 0;
			while (ph[7:0] === rv && n < 8) begin
				@(negedge clk_sys_i);
				n++;
			end
			rv = {rv[6:0], !rv[7]};
			check(ph[7:0], rv);
		end
		@(posedge exc.excitation_b);
		t0 = $realtime;
		@(posedge exc.excitation_a);
		check(int'(($realtime - t0) / 50) inside {[12:13]}, 1);
		repeat (8) @(posedge exc.excitation_b);
		check(int'(($realtime - t0) / 50) inside {[387:389]}, 1);
		foreach (rows[i]) begin
			@(posedge clk_sys_i);
			{msr, carry, at_tgt} <= rows[i][6:4];
			repeat (4) @(negedge clk_sys_i);
			check({sw.fwd_drive_on, sw.rev_drive_on, sw.speed_inc_on, sw.position_on}, rows[i][3:0]);
		end
		@(posedge clk_sys_i);
		{msr, carry, at_tgt} <= 3'h0;
		duty(6'h4, o1, e1);
		check({sw.even_fb_connect, tm.quad_c}, 2'h2);
		check(e1 - o1 inside {[180:208]}, 1);
		duty(6'hc, o2, e2);
		check(o1 - o2 inside {[56:72]}, 1);
		duty(6'h18, o3, e3);
		check(o3 > e3, 1);
		check({sw.even_fb_connect, tm.quad_c, tm.quad_d}, 3'h2);
		check({tm.code_e, tm.code_f}, 2'h3);
		@(posedge clk_sys_i);
		at_tgt <= 1'h1;
		duty(6'h4, o1, e1);
		check({tm.quad_c, tm.code_e, tm.code_f, sw.position_on}, 4'h7);
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		num_errors++;
		finish_test();
	end
endmodule
